// file: logic/crl_linkage.sv
// Call, return and interrupt linkage sequencer with its register file
`timescale 1ns/1ps
`default_nettype none
module crl_linkage #(
  parameter logic [15:0] VEC_LIMIT = crl_pkg::VEC_LIMIT_DEF
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire crl_pkg::crl_cmd_type cmd,
  output logic cmd_ready,
  output logic op_done,
  input wire logic intr_req,
  input wire logic [15:0] intr_vector,
  output logic intr_ack,
  output logic vec_err,
  input wire logic reg_wr_en,
  input wire logic [2:0] reg_wr_idx,
  input wire logic [15:0] reg_wr_data,
  input wire logic [2:0] reg_rd_idx,
  output logic [15:0] reg_rd_data,
  output logic [15:0] program_counter_register,
  output logic [15:0] system_stack_pointer,
  output logic [15:0] processor_status_word,
  output logic [1:0] cpu_mode,
  output logic reg_set,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);

  // Vector limit must leave room for a two-word vector at an even address
  if (VEC_LIMIT < 16'h0004 || VEC_LIMIT[0]) begin : g_bad_limit
    $error("VEC_LIMIT must be even and at least four");
  end

  // Whole state of the sequencer
  typedef struct packed {
    crl_pkg::crl_state_type st; // Sequencer state
    crl_pkg::crl_op_type op; // Operation in progress
    logic [2:0] ridx; // Linkage register of the operation
    logic [15:0] target; // Entry address of a call
    logic [15:0] vec; // Accepted vector address
    logic [7:0][15:0] regs; // General registers, SP and PC
    logic [15:0] psw; // Processor status word
    logic go; // Launch pulse to the memory port
    crl_pkg::crl_mem_op_type mop; // Access to launch
    logic ready; // Idle and able to take work
    logic done; // Operation finished pulse
    logic ack; // Interrupt taken pulse
    logic err; // Vector refused pulse
    logic [15:0] rd; // Register read port
    logic [1:0] mode; // Mode field of the status word
    logic rset; // Register set of the status word
  } crl_link_state_type;

  crl_link_state_type s_r; // Registered state
  crl_link_state_type s_nxt; // Next state
  logic mdone; // Memory access finished
  logic [15:0] mrdata; // Memory read data
  logic take_cmd; // Command taken this cycle
  logic take_int; // Interrupt request seen while idle
  logic vec_ok; // Vector is even and lies in the low kernel area

  // Memory word port
  crl_mem_port u_port (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .go(s_r.go),
    .op(s_r.mop),
    .done(mdone),
    .rdata(mrdata),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  // Commands win over an interrupt in the same idle cycle
  assign take_cmd = s_r.ready && cmd_valid;
  assign take_int = s_r.ready && !cmd_valid && intr_req;
  assign vec_ok = (intr_vector < VEC_LIMIT) && !intr_vector[0]; // [RULE5]

  // Sequencer next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.go = 1'b0;
    s_nxt.done = 1'b0;
    s_nxt.ack = 1'b0;
    s_nxt.err = 1'b0;
    case (s_r.st)
      crl_pkg::ST_IDLE: begin
        // Register load port works only while idle
        if (reg_wr_en && !take_cmd) begin
          s_nxt.regs[reg_wr_idx] = reg_wr_data;
        end
        if (take_cmd) begin
          s_nxt.op = cmd.op;
          s_nxt.ridx = cmd.reg_idx;
          s_nxt.target = cmd.target;
          case (cmd.op)
            crl_pkg::OP_CALL: begin
              // Save linkage register below the stack top
              s_nxt.mop = '{1'b1, crl_pkg::crl_stack_step(s_r.regs[crl_pkg::SP_IDX], 1'b0),
                s_r.regs[cmd.reg_idx]}; // [RULE10] [RULE12]
              s_nxt.go = 1'b1;
              s_nxt.st = crl_pkg::ST_PUSH_A;
            end
            crl_pkg::OP_JUMP: begin
              // Transfer with no linkage and no stack use
              s_nxt.regs[crl_pkg::PC_IDX] = cmd.target; // [RULE2]
              s_nxt.done = 1'b1;
            end
            crl_pkg::OP_RET: begin
              // Register to PC, then pop into the register
              s_nxt.regs[crl_pkg::PC_IDX] = s_r.regs[cmd.reg_idx]; // [RULE1]
              s_nxt.mop = '{1'b0, s_r.regs[crl_pkg::SP_IDX], 16'h0000};
              s_nxt.go = 1'b1;
              s_nxt.st = crl_pkg::ST_POP_A;
            end
            crl_pkg::OP_RTI: begin
              // Pop PC first
              s_nxt.mop = '{1'b0, s_r.regs[crl_pkg::SP_IDX], 16'h0000}; // [RULE7]
              s_nxt.go = 1'b1;
              s_nxt.st = crl_pkg::ST_POP_A;
            end
            crl_pkg::OP_MARK: begin
              // Skip the argument words, return through the link register
              s_nxt.regs[crl_pkg::SP_IDX] = 16'(s_r.regs[crl_pkg::PC_IDX]
                + {9'h000, cmd.count, 1'b0}); // [RULE9]
              s_nxt.regs[crl_pkg::PC_IDX] = s_r.regs[crl_pkg::MARK_LINK_IDX]; // [RULE9]
              // Pop address must already be the aligned pointer
              s_nxt.regs[crl_pkg::SP_IDX][0] = 1'b0; // [RULE11]
              s_nxt.mop = '{1'b0, s_nxt.regs[crl_pkg::SP_IDX], 16'h0000};
              s_nxt.go = 1'b1;
              s_nxt.st = crl_pkg::ST_POP_A;
            end
            default: begin
              // Unknown operation completes with no effect
              s_nxt.done = 1'b1;
            end
          endcase
        end else if (take_int) begin
          if (vec_ok) begin
            // Accept: push the status word first
            s_nxt.op = crl_pkg::OP_INT;
            s_nxt.vec = intr_vector;
            s_nxt.ack = 1'b1;
            s_nxt.mop = '{1'b1, crl_pkg::crl_stack_step(s_r.regs[crl_pkg::SP_IDX], 1'b0),
              s_r.psw}; // [RULE3]
            s_nxt.go = 1'b1;
            s_nxt.st = crl_pkg::ST_PUSH_A;
          end else begin
            // Vector outside the low kernel area is refused
            s_nxt.err = 1'b1; // [RULE5]
          end
        end
      end
      crl_pkg::ST_PUSH_A: begin
        if (mdone) begin
          // Pointer moves once the word is written
          s_nxt.regs[crl_pkg::SP_IDX] = crl_pkg::crl_stack_step(s_r.regs[crl_pkg::SP_IDX], 1'b0); // [RULE12]
          if (s_r.op == crl_pkg::OP_INT) begin
            // Then push the address of the next instruction
            s_nxt.mop = '{1'b1, crl_pkg::crl_stack_step(s_nxt.regs[crl_pkg::SP_IDX], 1'b0),
              s_r.regs[crl_pkg::PC_IDX]}; // [RULE3]
            s_nxt.go = 1'b1;
            s_nxt.st = crl_pkg::ST_PUSH_B;
          end else begin
            // Call: link gets return address, PC gets entry
            s_nxt.regs[s_r.ridx] = s_r.regs[crl_pkg::PC_IDX]; // [RULE10]
            s_nxt.regs[crl_pkg::PC_IDX] = s_r.target; // [RULE10]
            s_nxt.done = 1'b1;
            s_nxt.st = crl_pkg::ST_IDLE;
          end
        end
      end
      crl_pkg::ST_PUSH_B: begin
        if (mdone) begin
          // State saved; fetch new PC from the first vector word
          s_nxt.regs[crl_pkg::SP_IDX] = crl_pkg::crl_stack_step(s_r.regs[crl_pkg::SP_IDX], 1'b0); // [RULE12]
          s_nxt.mop = '{1'b0, s_r.vec, 16'h0000}; // [RULE4]
          s_nxt.go = 1'b1;
          s_nxt.st = crl_pkg::ST_VEC_A;
        end
      end
      crl_pkg::ST_VEC_A: begin
        if (mdone) begin
          // New PC, then status from the next word
          s_nxt.regs[crl_pkg::PC_IDX] = mrdata; // [RULE4]
          s_nxt.mop = '{1'b0, 16'(s_r.vec + crl_pkg::WORD_STEP), 16'h0000}; // [RULE4]
          s_nxt.go = 1'b1;
          s_nxt.st = crl_pkg::ST_VEC_B;
        end
      end
      crl_pkg::ST_VEC_B: begin
        if (mdone) begin
          // New status selects mode and register set
          s_nxt.psw = mrdata; // [RULE4] [RULE6]
          s_nxt.done = 1'b1;
          s_nxt.st = crl_pkg::ST_IDLE;
        end
      end
      crl_pkg::ST_POP_A: begin
        if (mdone) begin
          // Read the top word, then step the pointer up
          s_nxt.regs[crl_pkg::SP_IDX] = crl_pkg::crl_stack_step(s_r.regs[crl_pkg::SP_IDX], 1'b1); // [RULE12]
          if (s_r.op == crl_pkg::OP_RTI) begin
            s_nxt.regs[crl_pkg::PC_IDX] = mrdata; // [RULE7]
            s_nxt.mop = '{1'b0, s_nxt.regs[crl_pkg::SP_IDX], 16'h0000}; // [RULE7]
            s_nxt.go = 1'b1;
            s_nxt.st = crl_pkg::ST_POP_B;
          end else begin
            // Return and cleanup restore their link register
            s_nxt.regs[s_r.op == crl_pkg::OP_MARK ? crl_pkg::MARK_LINK_IDX : s_r.ridx] = mrdata; // [RULE1] [RULE9]
            s_nxt.done = 1'b1;
            s_nxt.st = crl_pkg::ST_IDLE;
          end
        end
      end
      crl_pkg::ST_POP_B: begin
        if (mdone) begin
          // Status word restored last, reversing the entry order
          s_nxt.regs[crl_pkg::SP_IDX] = crl_pkg::crl_stack_step(s_r.regs[crl_pkg::SP_IDX], 1'b1); // [RULE8]
          s_nxt.psw = mrdata; // [RULE7]
          s_nxt.done = 1'b1;
          s_nxt.st = crl_pkg::ST_IDLE;
        end
      end
      default: begin
        // Illegal code returns to idle
        s_nxt.st = crl_pkg::ST_IDLE;
      end
    endcase
    // Stack pointer can only hold even addresses
    s_nxt.regs[crl_pkg::SP_IDX][0] = 1'b0; // [RULE11]
    s_nxt.ready = (s_nxt.st == crl_pkg::ST_IDLE);
    s_nxt.rd = s_nxt.regs[reg_rd_idx];
    s_nxt.mode = s_nxt.psw[crl_pkg::MODE_LSB +: 2]; // [RULE6]
    s_nxt.rset = s_nxt.psw[crl_pkg::REGSET_BIT]; // [RULE6]
  end

  // State register with clock enable
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.st <= crl_pkg::ST_IDLE;
      s_r.ready <= 1'b1;
      s_r.psw <= crl_pkg::PSW_RESET;
      s_r.regs[crl_pkg::SP_IDX] <= crl_pkg::SP_RESET;
      s_r.regs[crl_pkg::PC_IDX] <= crl_pkg::PC_RESET;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign cmd_ready = s_r.ready;
  assign op_done = s_r.done;
  assign intr_ack = s_r.ack;
  assign vec_err = s_r.err;
  assign reg_rd_data = s_r.rd;
  assign program_counter_register = s_r.regs[crl_pkg::PC_IDX];
  assign system_stack_pointer = s_r.regs[crl_pkg::SP_IDX];
  assign processor_status_word = s_r.psw;
  assign cpu_mode = s_r.mode;
  assign reg_set = s_r.rset;

  // Checks on the sequencer, valid while the clock enable is high
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn || !ce);

  sequence call_taken;
    take_cmd && cmd.op == crl_pkg::OP_CALL;
  endsequence

  sp_even_a: assert property (!system_stack_pointer[0]) else $error("stack pointer odd"); // [RULE11]
  jump_nostack_a: assert property (take_cmd && cmd.op == crl_pkg::OP_JUMP |=> // [RULE2]
    program_counter_register == $past(cmd.target) && system_stack_pointer == $past(system_stack_pointer)
    && cmd_ready) else $error("jump touched stack");
  call_push_a: assert property (call_taken |=> s_r.st == crl_pkg::ST_PUSH_A ##1 mem_req && mem_we // [RULE10]
    && mem_wdata == $past(s_r.regs[cmd.reg_idx], 2)) else $error("call push wrong");
  push_addr_a: assert property (mem_req && mem_we && s_r.st != crl_pkg::ST_IDLE |-> // [RULE12]
    mem_addr == 16'(system_stack_pointer - crl_pkg::WORD_STEP)) else $error("push address wrong");
  pop_addr_a: assert property ((s_r.st == crl_pkg::ST_POP_A || s_r.st == crl_pkg::ST_POP_B) && mem_req // [RULE8]
    |-> !mem_we && mem_addr == system_stack_pointer) else $error("pop address wrong");
  int_order_a: assert property (s_r.op == crl_pkg::OP_INT && mem_req && mem_we |-> // [RULE3]
    mem_wdata == (s_r.st == crl_pkg::ST_PUSH_A ? s_r.psw : program_counter_register))
    else $error("interrupt push order wrong");
  vec_read_a: assert property ((s_r.st == crl_pkg::ST_VEC_A || s_r.st == crl_pkg::ST_VEC_B) && mem_req |-> // [RULE4]
    mem_addr == (s_r.st == crl_pkg::ST_VEC_A ? s_r.vec : 16'(s_r.vec + crl_pkg::WORD_STEP)))
    else $error("vector read wrong");
  vec_range_a: assert property (take_int |=> (intr_ack && s_r.vec < VEC_LIMIT) || vec_err) // [RULE5]
    else $error("vector check wrong");
  rti_psw_a: assert property (s_r.st == crl_pkg::ST_POP_B && mdone |=> // [RULE7]
    processor_status_word == $past(mrdata) && cmd_ready) else $error("status not restored");
  rts_pc_a: assert property (take_cmd && cmd.op == crl_pkg::OP_RET |=> // [RULE1]
    program_counter_register == $past(s_r.regs[cmd.reg_idx])) else $error("return PC wrong");
  mark_sp_a: assert property (take_cmd && cmd.op == crl_pkg::OP_MARK |=> // [RULE9]
    system_stack_pointer == (16'($past(program_counter_register) + {9'h000, $past(cmd.count), 1'b0}) & 16'hFFFE))
    else $error("cleanup pointer wrong");
  mode_follow_a: assert property ($changed(processor_status_word) |-> // [RULE6]
    cpu_mode == processor_status_word[15:14] && reg_set == processor_status_word[11]) else $error("mode stale");

endmodule : crl_linkage
`default_nettype wire

// file: common/crl_pkg.sv
// Constants, types and helpers shared by the call, return and interrupt linkage unit
// Function
// (RULE1) Subroutine return: register to PC, pop register
// (RULE2) Call uses linkage register; jump saves nothing
// (RULE3) Interrupt entry pushes status word, then PC
// (RULE4) New PC, then status, from vector
// (RULE5) Vectors lie in low kernel memory
// (RULE6) Loaded status sets mode and register set
// (RULE7) Interrupt return pops PC, then status word
// (RULE8) Stack saves and restores strictly last-in first-out
// (RULE9) Frame cleanup op discards arguments on return
// (RULE10) Call pushes link register, loads return, jumps
// (RULE11) System stack pointer stays word aligned
// (RULE12) Push predecrements by two; pop postincrements
package crl_pkg;

  // Register file indices
  localparam logic [2:0] MARK_LINK_IDX = 3'h5; // Link register used by frame cleanup
  localparam logic [2:0] SP_IDX = 3'h6; // System stack pointer
  localparam logic [2:0] PC_IDX = 3'h7; // Program counter register

  // Stack step and reset values
  localparam logic [15:0] WORD_STEP = 16'h0002; // One 16-bit word in bytes
  localparam logic [15:0] PC_RESET = 16'h0000; // Program counter after reset
  localparam logic [15:0] SP_RESET = 16'h1000; // Stack pointer after reset
  localparam logic [15:0] PSW_RESET = 16'h0000; // Status word after reset
  localparam logic [15:0] VEC_LIMIT_DEF = 16'h0400; // Top of the low vector area

  // Status word fields
  localparam int MODE_LSB = 14; // Operating mode, two bits
  localparam int REGSET_BIT = 11; // General register set select

  // Operations the sequencer runs
  typedef enum logic [2:0] {
    OP_CALL = 3'h0, // subroutine_call_op
    OP_JUMP = 3'h1, // plain_jump_op
    OP_RET = 3'h2, // Subroutine return through a register
    OP_RTI = 3'h3, // interrupt_return_op
    OP_MARK = 3'h4, // Stack frame cleanup
    OP_INT = 3'h5 // Internal: interrupt entry
  } crl_op_type;

  // One-hot sequencer states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_PUSH_A = 7'h02,
    ST_PUSH_B = 7'h04,
    ST_POP_A = 7'h08,
    ST_POP_B = 7'h10,
    ST_VEC_A = 7'h20,
    ST_VEC_B = 7'h40
  } crl_state_type;

  // Instruction command from the decoder
  typedef struct packed {
    crl_op_type op; // Operation
    logic [2:0] reg_idx; // Linkage register
    logic [15:0] target; // Entry or jump address
    logic [5:0] count; // Argument words for frame cleanup
  } crl_cmd_type;

  // One memory word access
  typedef struct packed {
    logic we; // High for write
    logic [15:0] addr; // Byte address
    logic [15:0] wdata; // Write data
  } crl_mem_op_type;

  // Stack pointer step: minus two for a push, plus two for a pop
  function automatic logic [15:0] crl_stack_step(input logic [15:0] sp, input logic pop);
    crl_stack_step = pop ? 16'(sp + WORD_STEP) : 16'(sp - WORD_STEP);
  endfunction : crl_stack_step

endpackage : crl_pkg

// file: logic/crl_mem_port.sv
// Memory word access port: holds a request until the memory acknowledges
`timescale 1ns/1ps
`default_nettype none
module crl_mem_port (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic go,
  input wire crl_pkg::crl_mem_op_type op,
  output logic done,
  output logic [15:0] rdata,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);

  // Whole state of the port
  typedef struct packed {
    logic req; // Request outstanding
    crl_pkg::crl_mem_op_type op; // Access being made
    logic done; // One-cycle completion
    logic [15:0] rdata; // Captured read data
  } crl_port_state_type;

  crl_port_state_type s_r; // Registered state
  crl_port_state_type s_nxt; // Next state

  // Launch on go, finish on acknowledge
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (!s_r.req && go) begin
      // New access starts next cycle
      s_nxt.req = 1'b1;
      s_nxt.op = op;
    end else if (s_r.req && mem_ack) begin
      // Access ends, read data is kept
      s_nxt.req = 1'b0;
      s_nxt.done = 1'b1;
      if (!s_r.op.we) begin
        s_nxt.rdata = mem_rdata;
      end
    end
  end

  // State register with clock enable
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign done = s_r.done;
  assign rdata = s_r.rdata;
  assign mem_req = s_r.req;
  assign mem_we = s_r.op.we;
  assign mem_addr = s_r.op.addr;
  assign mem_wdata = s_r.op.wdata;

endmodule : crl_mem_port
`default_nettype wire

// file: bench/crl_mem_model.sv
// Memory and interrupting peripheral model facing the linkage unit
`timescale 1ns/1ps
`default_nettype none
module crl_mem_model (
  input wire logic sys_clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  output logic intr_req,
  output logic [15:0] intr_vector,
  input wire logic intr_ack,
  input wire logic vec_err
);
  logic [15:0] mem [0:4095]; // Word store, byte address bits 12:1
  int dly = 0; // Wait cycles before each acknowledge
  int cnt = 0; // Cycles waited on the current access
  int n_acc = 0; // Accesses served so far
  bit pend = 0; // Request waiting to be raised
  logic [15:0] pend_vec = 16'h0000; // Vector of the waiting request
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
    intr_req = 1'b0;
    intr_vector = 16'h0000;
  end
  // Memory side: answer after dly cycles, data not held once released
  always @(negedge sys_clk) begin
    if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && cnt >= dly) begin
      mem_ack <= 1'b1;
      cnt <= 0;
      n_acc <= n_acc + 1;
      if (mem_we)
        mem[mem_addr[12:1]] <= mem_wdata;
      else
        mem_rdata <= mem[mem_addr[12:1]];
    end else if (mem_req) begin
      cnt <= cnt + 1;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
  // Peripheral side: hold request and vector until accepted or refused
  always @(negedge sys_clk) begin
    if (pend) begin
      intr_req <= 1'b1;
      intr_vector <= pend_vec; // Designer-chosen low vector
      pend = 0;
    end else if (intr_req && (intr_ack || vec_err)) begin
      intr_req <= 1'b0;
    end else if (!intr_req) begin
      intr_vector <= ~intr_vector; // Vector lines not held while idle
    end
  end
  // Queue one interrupt request
  task automatic raise(input logic [15:0] vec);
    pend_vec = vec;
    pend = 1;
  endtask : raise
endmodule : crl_mem_model
`default_nettype wire

// file: bench/tb_call_return_interrupt_linkage.sv
// Self-checking testbench of the call, return and interrupt linkage unit
`timescale 1ns/1ps
`default_nettype none
module tb_call_return_interrupt_linkage;
  logic sys_clk, rstn, ce, cmd_valid, cmd_ready, op_done, intr_req, intr_ack, vec_err;
  logic reg_wr_en, reg_set, mem_req, mem_we, mem_ack;
  logic [2:0] reg_wr_idx, reg_rd_idx;
  logic [1:0] cpu_mode;
  logic [15:0] intr_vector, reg_wr_data, reg_rd_data, mem_addr, mem_wdata, mem_rdata;
  logic [15:0] program_counter_register, system_stack_pointer, processor_status_word;
  crl_pkg::crl_cmd_type cmd; // Command offered to the unit
  int n_errors = 0; // Mismatches seen
  int n_compared = 0; // Comparisons made
  int lat; // Cycles from take to completion
  bit seen_ack, seen_err; // Interrupt answers seen during a wait
  logic [15:0] rv; // Register read back
  // Design under test
  crl_linkage dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .op_done(op_done), .intr_req(intr_req), .intr_vector(intr_vector),
    .intr_ack(intr_ack), .vec_err(vec_err), .reg_wr_en(reg_wr_en), .reg_wr_idx(reg_wr_idx),
    .reg_wr_data(reg_wr_data), .reg_rd_idx(reg_rd_idx), .reg_rd_data(reg_rd_data),
    .program_counter_register(program_counter_register), .system_stack_pointer(system_stack_pointer),
    .processor_status_word(processor_status_word), .cpu_mode(cpu_mode), .reg_set(reg_set),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // Memory and interrupting peripheral
  crl_mem_model mdl (.sys_clk(sys_clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .intr_req(intr_req),
    .intr_vector(intr_vector), .intr_ack(intr_ack), .vec_err(vec_err));
  // Free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Verdict and end of run
  task automatic test_done();
    $display("Counts: compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  // Compare one value
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Wait, bounded, for completion or a refused vector
  task automatic wait_evt();
    seen_ack = 0;
    seen_err = 0;
    for (lat = 1; lat < 300; lat++) begin
      // Look first: a one-cycle answer already stands at the first falling edge
      seen_ack |= (intr_ack === 1'b1);
      seen_err |= (vec_err === 1'b1);
      if (op_done === 1'b1 || vec_err === 1'b1) return;
      @(negedge sys_clk);
    end
    n_errors++;
    $display("ERROR op_done expected 1 seen timeout");
    test_done();
  endtask : wait_evt
  // Offer one command at a falling edge and wait for it
  task automatic issue(input crl_pkg::crl_op_type op, input logic [2:0] r, input logic [15:0] t,
                       input logic [5:0] n);
    cmd_valid = 1'b1;
    cmd = '{op: op, reg_idx: r, target: t, count: n};
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    wait_evt();
    @(negedge sys_clk);
    chk("op_done low", 16'h0000, {15'h0000, op_done});
    chk("cmd_ready", 16'h0001, {15'h0000, cmd_ready});
  endtask : issue
  // Load and read general registers
  task automatic setreg(input logic [2:0] idx, input logic [15:0] val);
    reg_wr_en = 1'b1;
    reg_wr_idx = idx;
    reg_wr_data = val;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
  endtask : setreg
  task automatic getreg(input logic [2:0] idx);
    reg_rd_idx = idx;
    @(negedge sys_clk);
    rv = reg_rd_data;
  endtask : getreg
  // Check program counter, stack pointer and status word together
  task automatic st(input logic [15:0] pc, input logic [15:0] sp, input logic [15:0] psw);
    chk("pc", pc, program_counter_register);
    chk("sp", sp, system_stack_pointer);
    chk("psw", psw, processor_status_word);
  endtask : st
  // Take one interrupt through vector v
  task automatic take_intr(input logic [15:0] v);
    mdl.raise(v);
    wait_evt();
    chk("intr_ack", 16'h0001, {15'h0000, seen_ack});
  endtask : take_intr
  // Jump moves the PC only, with no stack traffic
  task automatic t_jump();
    int acc;
    acc = mdl.n_acc;
    issue(crl_pkg::OP_JUMP, 3'h3, 16'h0246, 6'h00);
    chk("jump latency", 16'h0001, 16'(lat));
    chk("jump accesses", 16'(acc), 16'(mdl.n_acc));
    st(16'h0246, 16'h1000, 16'h0000);
    // Unknown operation code completes at once with no effect
    issue(crl_pkg::crl_op_type'(3'h6), 3'h0, 16'h0ABC, 6'h00);
    chk("unknown op latency", 16'h0001, 16'(lat));
    st(16'h0246, 16'h1000, 16'h0000);
    $display("Test jump done");
  endtask : t_jump
  // Clock enable low freezes the unit, a command offered then is not taken
  task automatic t_freeze();
    ce = 1'b0;
    cmd_valid = 1'b1;
    cmd = '{op: crl_pkg::OP_JUMP, reg_idx: 3'h0, target: 16'h0ABC, count: 6'h00};
    repeat (3) @(negedge sys_clk);
    cmd_valid = 1'b0;
    ce = 1'b1;
    @(negedge sys_clk);
    chk("frozen pc", 16'h0246, program_counter_register);
    chk("frozen cmd_ready", 16'h0001, {15'h0000, cmd_ready});
    $display("Test clock enable done");
  endtask : t_freeze
  // Call through R5 then return through R5
  task automatic t_call_ret();
    setreg(3'h5, 16'h1234);
    issue(crl_pkg::OP_CALL, 3'h5, 16'h0500, 6'h00);
    chk("pushed link", 16'h1234, mdl.mem[12'h7FF]);
    st(16'h0500, 16'h0FFE, 16'h0000);
    getreg(3'h5);
    chk("link gets return", 16'h0246, rv);
    issue(crl_pkg::OP_RET, 3'h5, 16'h0000, 6'h00);
    st(16'h0246, 16'h1000, 16'h0000);
    getreg(3'h5);
    chk("link restored", 16'h1234, rv);
    $display("Test call and return done");
  endtask : t_call_ret
  // Interrupt, call, nested interrupt, then unwind in reverse
  task automatic t_nest();
    mdl.dly = 3;
    mdl.mem[12'h080] = 16'h2000;
    mdl.mem[12'h081] = 16'hC800;
    mdl.mem[12'h082] = 16'h4000;
    mdl.mem[12'h083] = 16'h4000;
    take_intr(16'h0100);
    chk("saved psw", 16'h0000, mdl.mem[12'h7FF]);
    chk("saved pc", 16'h0246, mdl.mem[12'h7FE]);
    st(16'h2000, 16'h0FFC, 16'hC800);
    chk("mode", 16'h0003, {14'h0000, cpu_mode});
    chk("reg_set", 16'h0001, {15'h0000, reg_set});
    issue(crl_pkg::OP_CALL, 3'h7, 16'h3000, 6'h00);
    chk("pushed pc", 16'h2000, mdl.mem[12'h7FD]);
    st(16'h3000, 16'h0FFA, 16'hC800);
    take_intr(16'h0104);
    st(16'h4000, 16'h0FF6, 16'h4000);
    chk("mode nested", 16'h0001, {14'h0000, cpu_mode});
    chk("reg_set nested", 16'h0000, {15'h0000, reg_set});
    issue(crl_pkg::OP_RTI, 3'h0, 16'h0000, 6'h00);
    st(16'h3000, 16'h0FFA, 16'hC800);
    issue(crl_pkg::OP_RET, 3'h7, 16'h0000, 6'h00);
    st(16'h2000, 16'h0FFC, 16'hC800);
    issue(crl_pkg::OP_RTI, 3'h0, 16'h0000, 6'h00);
    st(16'h0246, 16'h1000, 16'h0000);
    chk("mode back", 16'h0000, {14'h0000, cpu_mode});
    mdl.dly = 0;
    $display("Test nesting done");
  endtask : t_nest
  // Odd vector and vector at the limit are refused
  task automatic t_badvec();
    logic [15:0] bad [2];
    bad = '{16'h0101, 16'h0400};
    foreach (bad[i]) begin
      mdl.raise(bad[i]);
      wait_evt();
      chk("vec_err", 16'h0001, {15'h0000, seen_err});
      chk("no intr_ack", 16'h0000, {15'h0000, seen_ack});
      repeat (4) @(negedge sys_clk);
      st(16'h0246, 16'h1000, 16'h0000);
    end
    $display("Test refused vectors done");
  endtask : t_badvec
  // Frame cleanup drops three argument words on return
  task automatic t_mark();
    setreg(3'h5, 16'h0777);
    mdl.mem[12'h126] = 16'h5A5A;
    issue(crl_pkg::OP_MARK, 3'h0, 16'h0000, 6'h03);
    st(16'h0777, 16'h024E, 16'h0000);
    getreg(3'h5);
    chk("cleanup link", 16'h5A5A, rv);
    $display("Test frame cleanup done");
  endtask : t_mark
  // Main sequence
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    reg_wr_en = 1'b0;
    reg_wr_idx = 3'h0;
    reg_wr_data = 16'h0000;
    reg_rd_idx = 3'h0;
    repeat (6) @(negedge sys_clk);
    rstn = 1'b1;
    st(16'h0000, 16'h1000, 16'h0000);
    chk("reset cmd_ready", 16'h0001, {15'h0000, cmd_ready});
    chk("reset mem_req", 16'h0000, {15'h0000, mem_req});
    t_jump();
    t_freeze();
    t_call_ret();
    t_nest();
    t_badvec();
    t_mark();
    test_done();
  end
endmodule : tb_call_return_interrupt_linkage
`default_nettype wire
